// [hdl/adc_ctl_pkg.sv]
// constants for the converter control and result register block
// assumes an AHB-Lite slave with 32-bit data, one register per word
package adc_ctl_pkg;
	localparam logic [7:0] OFS_RESULT_LOW = 8'h00;
	localparam logic [7:0] OFS_RESULT_HIGH = 8'h04;
	localparam logic [7:0] OFS_CTRL_MAIN = 8'h08;
	localparam logic [7:0] OFS_CTRL_AUX = 8'h0c;
	localparam logic [7:0] OFS_PIN_EN = 8'h10;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
	localparam logic [7:0] OFS_CONV_DATA = 8'h1c;
	// conv_control_main fields
	localparam int BIT_START = 7;
	localparam int BIT_BUSY = 6;
	localparam int BIT_POWER_OFF = 5;
	localparam int BIT_JUSTIFY = 4;
	localparam int BIT_AMP_SEL = 3;
	localparam int CH_MSB = 2;
	// conv_control_aux fields
	localparam int BIT_INT_REF = 7;
	localparam int BIT_BG_EN = 6;
	localparam int BIT_REF_SRC = 4;
	localparam int DIV_MSB = 2;
	localparam logic [7:0] AUX_WRITE_MASK = 8'hd7;
	localparam logic [7:0] RESET_CTRL_MAIN = 8'h60;
	localparam logic [7:0] RESET_CTRL_AUX = 8'h00;
	localparam logic [7:0] RESET_PIN_EN = 8'hff;
	localparam logic [2:0] DIV_UNDEFINED = 3'h7;
	localparam logic [4:0] CONV_PERIODS = 5'h10;
	localparam logic [5:0] DIV_MAX = 6'h3f;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ARMED = 3'b010,
		ST_CONV = 3'b100
	} conv_state_t;
endpackage

// [hdl/adc_control_and_result_regs.sv]
// converter control, result registers and end-of-conversion interrupt
// assumes one clock; analog core returns its 12-bit sample on core_result
// Contract
// - justify bit places 12-bit result in bytes
// - channel selector routes one source
// - analog enable bit takes pin from digital
// - analog pin drops its pull-high
// - start low-high-low begins a conversion
// - start held high resets core, busy high
// - busy reads one during conversion, clears after
// - conversion end sets interrupt request flag
// - clock divider one to sixty-four by code
// - reference select routes external reference pin
// - bandgap off unless enabled or needed
// - internal reference channel excludes other inputs
// - aux bits 5 and 3 read zero
// - power-off bit resets to one, stops converter
// - conversion lasts sixteen converter clocks
//
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/1ns
module adc_control_and_result_regs (
	input wire logic clk, // 20 MHz system clock
	input wire logic reset_n, // async reset, active low
	input wire logic hsel, // slave select
	input wire logic [7:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // transfer size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready in
	output logic [31:0] hrdata, // read data
	output logic hreadyout, // slave ready
	output logic hresp, // always okay
	input wire logic [11:0] core_result, // sample from analog core
	input wire logic low_voltage_fn_on, // low-voltage functions active
	output logic core_reset, // holds analog core in reset
	output logic core_power_off, // analog core switched off
	output logic conv_clock, // converter clock enable pulse
	output logic [7:0] pin_analog_en, // pin used as analog input
	output logic [7:0] pin_pullhigh_cut, // forces pull-high off
	output logic [7:0] analog_input_route, // one-hot external channel
	output logic internal_amp_route, // amplifier channel routed
	output logic bandgap_route, // 1.25V routed to converter
	output logic bandgap_on, // bandgap powered
	output logic reference_pin_sel, // external reference pin in use
	output logic conv_irq // level interrupt
);
	logic [7:0] ctrl_main;
	logic [7:0] ctrl_aux;
	logic [7:0] pin_en;
	logic [11:0] sample;
	logic irq_status;
	logic irq_mask;
	logic busy;
	logic start_prev;
	logic [5:0] div_cnt;
	logic [4:0] period_cnt;
	logic tick;
	logic ap_write;
	logic ap_read;
	logic [7:0] ap_addr;
	logic conv_done;
	logic [10:0] conv_cycles;
	adc_ctl_pkg::conv_state_t state;

	function automatic logic [5:0] div_limit(input logic [2:0] code);
		div_limit = 6'((7'h01 << code) - 7'h01);
	endfunction

	// last cycle count of a conversion for a divider code
	function automatic logic [10:0] conv_span(input logic [2:0] code);
		conv_span = ({6'h00, adc_ctl_pkg::CONV_PERIODS} << code) - 11'h001;
	endfunction

	function automatic logic [7:0] fold(input logic [7:0] cur,
			input logic [31:0] wd, input logic [7:0] mask);
		fold = (cur & ~mask) | (wd[7:0] & mask);
	endfunction

	wire logic start_bit = ctrl_main[adc_ctl_pkg::BIT_START];
	wire logic justify = ctrl_main[adc_ctl_pkg::BIT_JUSTIFY];
	wire logic power_off = ctrl_main[adc_ctl_pkg::BIT_POWER_OFF];
	wire logic [2:0] div_sel = ctrl_aux[adc_ctl_pkg::DIV_MSB:0];
	wire logic write_hit = ap_write;

	// bus slave: zero-wait, registered address phase
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ap_write <= 1'b0;
			ap_read <= 1'b0;
			ap_addr <= 8'h00;
		end else if (hready) begin
			ap_write <= hsel && htrans == adc_ctl_pkg::HTRANS_NONSEQ && hwrite;
			ap_read <= hsel && htrans == adc_ctl_pkg::HTRANS_NONSEQ && !hwrite;
			ap_addr <= haddr;
		end else begin
			ap_write <= 1'b0;
			ap_read <= 1'b0;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// control registers; busy bit is never writable
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_main <= adc_ctl_pkg::RESET_CTRL_MAIN;
			ctrl_aux <= adc_ctl_pkg::RESET_CTRL_AUX;
			pin_en <= adc_ctl_pkg::RESET_PIN_EN;
			irq_mask <= 1'b0;
		end else if (write_hit) begin
			unique case (ap_addr)
				adc_ctl_pkg::OFS_CTRL_MAIN: ctrl_main <= fold(ctrl_main, hwdata,
						~(8'h01 << adc_ctl_pkg::BIT_BUSY));
				adc_ctl_pkg::OFS_CTRL_AUX: ctrl_aux <= fold(ctrl_aux, hwdata,
						adc_ctl_pkg::AUX_WRITE_MASK);
				adc_ctl_pkg::OFS_PIN_EN: pin_en <= hwdata[7:0];
				adc_ctl_pkg::OFS_IRQ_MASK: irq_mask <= hwdata[0];
				default: ;
			endcase
		end
	end

	// clock divider, counts only while powered
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt <= 6'h00;
		end else if (power_off || state != adc_ctl_pkg::ST_CONV) begin
			div_cnt <= 6'h00;
		end else if (div_cnt >= div_limit(div_sel)) begin
			div_cnt <= 6'h00;
		end else begin
			div_cnt <= div_cnt + 6'h01;
		end
	end

	assign tick = state == adc_ctl_pkg::ST_CONV &&
			div_sel != adc_ctl_pkg::DIV_UNDEFINED &&
			div_cnt >= div_limit(div_sel);
	assign conv_done = tick && period_cnt == adc_ctl_pkg::CONV_PERIODS - 5'h01;

	// start sequencing and conversion timing
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= adc_ctl_pkg::ST_IDLE;
			start_prev <= 1'b0;
			period_cnt <= 5'h00;
		end else begin
			start_prev <= start_bit;
			unique case (state)
				adc_ctl_pkg::ST_IDLE: if (start_bit && !start_prev) begin
					state <= adc_ctl_pkg::ST_ARMED;
				end
				adc_ctl_pkg::ST_ARMED: if (!start_bit && !power_off) begin
					state <= adc_ctl_pkg::ST_CONV;
					period_cnt <= 5'h00;
				end
				adc_ctl_pkg::ST_CONV: if (start_bit || power_off) begin
					state <= start_bit ? adc_ctl_pkg::ST_ARMED :
							adc_ctl_pkg::ST_IDLE;
				end else if (conv_done) begin
					state <= adc_ctl_pkg::ST_IDLE;
				end else if (tick) begin
					period_cnt <= period_cnt + 5'h01;
				end
				default: state <= adc_ctl_pkg::ST_IDLE;
			endcase
		end
	end

	// cycles spent in the current conversion, for the length check
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			conv_cycles <= 11'h000;
		end else if (state != adc_ctl_pkg::ST_CONV) begin
			conv_cycles <= 11'h000;
		end else begin
			conv_cycles <= conv_cycles + 11'h001;
		end
	end

	// busy flag, reset value one, clears when conversion ends
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			busy <= 1'b1;
		end else if (state == adc_ctl_pkg::ST_ARMED) begin
			busy <= 1'b1;
		end else if (conv_done && !start_bit && !power_off) begin
			busy <= 1'b0;
		end
	end

	// result captured with the same edge that clears busy
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sample <= 12'h000;
		end else if (conv_done && !start_bit && !power_off) begin
			sample <= core_result;
		end
	end

	// sticky end-of-conversion flag, set wins over write-one clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_status <= 1'b0;
		end else if (conv_done && !start_bit && !power_off) begin
			irq_status <= 1'b1;
		end else if (write_hit && ap_addr == adc_ctl_pkg::OFS_IRQ_STATUS &&
				hwdata[0]) begin
			irq_status <= 1'b0;
		end
	end

	assign conv_irq = irq_status && irq_mask;

	logic [7:0] res_low;
	logic [7:0] res_high;
	always_comb begin
		if (justify) begin
			res_low = sample[7:0];
			res_high = {4'h0, sample[11:8]};
		end else begin
			res_low = {sample[3:0], 4'h0};
			res_high = sample[11:4];
		end
	end

	// control byte as read: busy bit comes from the live flag
	logic [7:0] main_view;
	always_comb begin
		main_view = ctrl_main;
		main_view[adc_ctl_pkg::BIT_BUSY] = busy;
	end

	// read data registered in the data phase
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && !hwrite &&
				htrans == adc_ctl_pkg::HTRANS_NONSEQ) begin
			unique case (haddr)
				adc_ctl_pkg::OFS_RESULT_LOW: hrdata <= {24'h0, res_low};
				adc_ctl_pkg::OFS_RESULT_HIGH: hrdata <= {24'h0, res_high};
				adc_ctl_pkg::OFS_CTRL_MAIN: hrdata <= {24'h0, main_view};
				adc_ctl_pkg::OFS_CTRL_AUX: hrdata <= {24'h0,
						ctrl_aux & adc_ctl_pkg::AUX_WRITE_MASK};
				adc_ctl_pkg::OFS_PIN_EN: hrdata <= {24'h0, pin_en};
				adc_ctl_pkg::OFS_IRQ_STATUS: hrdata <= {31'h0, irq_status};
				adc_ctl_pkg::OFS_IRQ_MASK: hrdata <= {31'h0, irq_mask};
				adc_ctl_pkg::OFS_CONV_DATA: hrdata <= {20'h0, sample};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// analog side control
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_analog_en <= adc_ctl_pkg::RESET_PIN_EN;
			pin_pullhigh_cut <= adc_ctl_pkg::RESET_PIN_EN;
			analog_input_route <= 8'h00;
			internal_amp_route <= 1'b0;
			bandgap_route <= 1'b0;
			bandgap_on <= 1'b0;
			reference_pin_sel <= 1'b0;
			core_reset <= 1'b1;
			core_power_off <= 1'b1;
			conv_clock <= 1'b0;
		end else begin
			pin_analog_en <= pin_en;
			pin_pullhigh_cut <= pin_en;
			bandgap_route <= ctrl_aux[adc_ctl_pkg::BIT_INT_REF];
			analog_input_route <= ctrl_aux[adc_ctl_pkg::BIT_INT_REF] ||
					ctrl_main[adc_ctl_pkg::BIT_AMP_SEL] ? 8'h00 :
					8'(8'h01 << ctrl_main[adc_ctl_pkg::CH_MSB:0]);
			internal_amp_route <= !ctrl_aux[adc_ctl_pkg::BIT_INT_REF] &&
					ctrl_main[adc_ctl_pkg::BIT_AMP_SEL];
			bandgap_on <= ctrl_aux[adc_ctl_pkg::BIT_BG_EN] ||
					low_voltage_fn_on;
			reference_pin_sel <= ctrl_aux[adc_ctl_pkg::BIT_REF_SRC];
			core_reset <= state != adc_ctl_pkg::ST_CONV;
			core_power_off <= power_off;
			conv_clock <= tick;
		end
	end

	AST_BUSY_AFTER_START: assert property (
		@(posedge clk) disable iff (!reset_n)
		state == adc_ctl_pkg::ST_ARMED |=> busy)
		else $error("busy not set while start high");
	AST_CORE_RESET: assert property (
		@(posedge clk) disable iff (!reset_n)
		state == adc_ctl_pkg::ST_ARMED |=> core_reset)
		else $error("core not reset while armed");
	AST_START_SEQ: assert property (
		@(posedge clk) disable iff (!reset_n)
		state == adc_ctl_pkg::ST_ARMED && !start_bit && !power_off
		|=> state == adc_ctl_pkg::ST_CONV)
		else $error("conversion did not begin");
	AST_IRQ_SET: assert property (
		@(posedge clk) disable iff (!reset_n)
		conv_done && !start_bit && !power_off |=> irq_status && !busy)
		else $error("end flag not set");
	AST_IRQ_LEVEL: assert property (
		@(posedge clk) disable iff (!reset_n)
		!irq_status && !conv_done |=> !conv_irq)
		else $error("interrupt raised without conversion end");
	AST_DIV_RANGE: assert property (
		@(posedge clk) disable iff (!reset_n)
		state != adc_ctl_pkg::ST_CONV |=> div_cnt == 6'h00)
		else $error("divider ran outside a conversion");
	AST_PULL_CUT: assert property (
		@(posedge clk) disable iff (!reset_n)
		pin_pullhigh_cut == $past(pin_en))
		else $error("pull-high not cut on analog pin");
	AST_ONE_SOURCE: assert property (
		@(posedge clk) disable iff (!reset_n)
		bandgap_route |-> analog_input_route == 8'h00 && !internal_amp_route)
		else $error("two sources routed");
	AST_SAMPLE_HELD: assert property (
		@(posedge clk) disable iff (!reset_n)
		busy |=> $stable(sample) || !busy)
		else $error("result changed mid conversion");
	AST_RESULT_AT_END: assert property (
		@(posedge clk) disable iff (!reset_n)
		conv_done && !start_bit && !power_off |=> sample == $past(core_result))
		else $error("result not taken at conversion end");
	AST_CONV_LENGTH: assert property (
		@(posedge clk) disable iff (!reset_n)
		conv_done |-> conv_cycles == conv_span(div_sel))
		else $error("conversion length wrong");
	AST_POWER_OFF: assert property (
		@(posedge clk) disable iff (!reset_n)
		power_off |=> state != adc_ctl_pkg::ST_CONV)
		else $error("converter ran while powered off");
	AST_UNUSED_ZERO: assert property (
		@(posedge clk) disable iff (!reset_n)
		justify ? res_high[7:4] == 4'h0 : res_low[3:0] == 4'h0)
		else $error("unused result bits not zero");
	COV_CONV: cover property (@(posedge clk) disable iff (!reset_n)
		state == adc_ctl_pkg::ST_CONV ##1 state == adc_ctl_pkg::ST_IDLE);
	COV_IRQ: cover property (@(posedge clk) disable iff (!reset_n)
		$rose(conv_irq));
	COV_ABORT: cover property (@(posedge clk) disable iff (!reset_n)
		state == adc_ctl_pkg::ST_CONV ##1 state == adc_ctl_pkg::ST_ARMED);
	COV_SLOW_DIV: cover property (@(posedge clk) disable iff (!reset_n)
		conv_done && div_sel == 3'h6);
endmodule // adc_control_and_result_regs

// [tb/adc_core_model.sv]
// stand-in for the analog core: converts a sample set by the bench
// assumes core_reset high outside conversions
`timescale 1ns/1ns
module adc_core_model (
	input wire logic clk, // system clock
	input wire logic core_reset, // core held in reset
	input wire logic core_power_off, // core switched off
	input wire logic [11:0] sample, // value to convert
	output logic [11:0] core_result // converted value
);
	logic [11:0] last = 12'h000;
	// no valid data when idle or off: output flips every cycle
	always_ff @(posedge clk) begin
		if (core_reset || core_power_off) begin
			last <= ~last;
		end else begin
			last <= sample;
		end
	end
	assign core_result = last;
endmodule // adc_core_model

// [tb/tb.sv]
// self-checking bench for the converter control block
// assumes one bus master and the core stand-in model
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
	$display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module tb;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic lv_fn_on = 1'b0;
	logic [11:0] sample = 12'h000;
	logic [31:0] hrdata, rd;
	logic hreadyout, hresp, core_reset, core_power_off, conv_clock;
	logic internal_amp_route, bandgap_route, bandgap_on;
	logic reference_pin_sel, conv_irq;
	logic [11:0] core_result;
	logic [7:0] pin_analog_en, pin_pullhigh_cut, analog_input_route;
	int n_fail = 0;
	int checked = 0;
	always #25 clk = ~clk;
	adc_control_and_result_regs u_dut (.clk, .reset_n, .hsel, .haddr,
		.htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
		.hrdata, .hreadyout, .hresp, .core_result, .low_voltage_fn_on(lv_fn_on),
		.core_reset, .core_power_off, .conv_clock, .pin_analog_en,
		.pin_pullhigh_cut, .analog_input_route, .internal_amp_route,
		.bandgap_route, .bandgap_on, .reference_pin_sel, .conv_irq);
	adc_core_model u_core (.clk, .core_reset, .core_power_off, .sample,
		.core_result);
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= adc_ctl_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= {24'h0, d};
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic t_reset;
		xfer(0, adc_ctl_pkg::OFS_CTRL_MAIN, 8'h00);
		`CHK(rd, 32'h60)
		`CHK(core_power_off, 1'b1)
		`CHK(hresp, 1'b0)
		xfer(0, adc_ctl_pkg::OFS_PIN_EN, 8'h00);
		`CHK(rd, 32'hff)
		xfer(1, adc_ctl_pkg::OFS_CTRL_AUX, 8'hff);
		xfer(0, adc_ctl_pkg::OFS_CTRL_AUX, 8'h00);
		`CHK(rd, 32'hd7)
		xfer(1, 8'h20, 8'hff);
		xfer(0, 8'h20, 8'h00);
		`CHK(rd, 32'h0)
		$display("test reset done");
	endtask
	task automatic t_route;
		xfer(1, adc_ctl_pkg::OFS_PIN_EN, 8'h5a);
		xfer(1, adc_ctl_pkg::OFS_CTRL_MAIN, 8'h23);
		xfer(1, adc_ctl_pkg::OFS_CTRL_AUX, 8'h00);
		repeat (2) @(posedge clk);
		`CHK(pin_analog_en, 8'h5a)
		`CHK(pin_pullhigh_cut, 8'h5a)
		`CHK(analog_input_route, 8'h08)
		`CHK(bandgap_on, 1'b0)
		xfer(1, adc_ctl_pkg::OFS_CTRL_MAIN, 8'ha3);
		xfer(1, adc_ctl_pkg::OFS_CTRL_MAIN, 8'h23);
		repeat (4) @(posedge clk);
		`CHK(core_reset, 1'b1)
		lv_fn_on <= 1'b1;
		xfer(1, adc_ctl_pkg::OFS_CTRL_MAIN, 8'h28);
		repeat (2) @(posedge clk);
		`CHK({internal_amp_route, analog_input_route}, 9'h100)
		`CHK(bandgap_on, 1'b1)
		lv_fn_on <= 1'b0;
		xfer(1, adc_ctl_pkg::OFS_CTRL_AUX, 8'hd0);
		repeat (2) @(posedge clk);
		`CHK({bandgap_route, analog_input_route}, 9'h100)
		`CHK({bandgap_on, reference_pin_sel}, 2'h3)
		$display("test routing done");
	endtask
	task automatic conv(input logic [2:0] dv, input logic j);
		int i;
		int n;
		int p;
		logic [11:0] s;
		s = 12'ha5c ^ {9'h0, dv};
		sample <= s;
		xfer(1, adc_ctl_pkg::OFS_IRQ_MASK, {7'h0, ~j});
		xfer(1, adc_ctl_pkg::OFS_CTRL_AUX, {5'h0, dv});
		xfer(1, adc_ctl_pkg::OFS_CTRL_MAIN, {3'h4, j, 4'h1});
		repeat (2) @(posedge clk);
		xfer(0, adc_ctl_pkg::OFS_CTRL_MAIN, 8'h00);
		`CHK(rd[6], 1'b1)
		`CHK(core_reset, 1'b1)
		xfer(1, adc_ctl_pkg::OFS_CTRL_MAIN, {3'h0, j, 4'h1});
		i = 0;
		while (core_reset !== 1'b0 && i < 10) begin
			@(posedge clk);
			i++;
		end
		n = 0;
		p = 0;
		while (core_reset === 1'b0 && n < 2000) begin
			if (conv_clock === 1'b1) begin
				p++;
			end
			@(posedge clk);
			n++;
		end
		`CHK(n, 16 << dv)
		`CHK(p, 16)
		xfer(0, adc_ctl_pkg::OFS_CTRL_MAIN, 8'h00);
		`CHK(rd[6], 1'b0)
		xfer(0, adc_ctl_pkg::OFS_RESULT_HIGH, 8'h00);
		`CHK(rd, {24'h0, j ? {4'h0, s[11:8]} : s[11:4]})
		xfer(0, adc_ctl_pkg::OFS_RESULT_LOW, 8'h00);
		`CHK(rd, {24'h0, j ? s[7:0] : {s[3:0], 4'h0}})
		xfer(0, adc_ctl_pkg::OFS_IRQ_STATUS, 8'h00);
		`CHK({rd[0], conv_irq}, {1'b1, ~j})
		xfer(1, adc_ctl_pkg::OFS_IRQ_STATUS, 8'h01);
		@(posedge clk);
		`CHK(conv_irq, 1'b0)
		$display("test conversion code %0d done", dv);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_route();
		for (int d = 0; d < 7; d++) begin
			conv(d[2:0], d[0]);
		end
		print_verdict();
	end
	initial begin
		#(50 * 20000);
		n_fail++;
		print_verdict();
	end
endmodule // tb
